/* File: rtl/mic_pkg.sv */
/*
 * Constants shared by the maskable interrupt priority controller:
 * register indices, field positions, reset values, vector layout.
 * Assumes a single 10 MHz clock domain and word-indexed register port.
 */
// Summary of operation
// - NMI in service sets flag, blocks further NMI
// - fifty-five independently maskable request sources
// - any acceptance disables further maskable acceptance
// - re-enabled handler nests strictly higher levels only
// - entry saves PC and status word
// - maskable entry writes cause code, low half only
// - entry sets disable, clears pending, loads handler
// - masked or disabled requests stay pending
// - lower requests wait behind higher pending ones
// - return restores PC and status from saved
// - return clears in-service bit of exited level
// - eight programmable levels per source
// - equal levels resolved by fixed default order
// - highest programmable level accepted first
// - equal level: higher default priority first
// - lower level than in service stays pending
// - level zero highest, seven lowest
// - acceptance clears the source request flag
// - source control resets to 47H
package mic_pkg;
    localparam int          N_SRC       = 55;
    localparam int          IDX_W       = 6;
    localparam int          LVL_W       = 3;
    localparam int          ADDR_W      = 8;
    // source control register fields
    localparam int          CTL_IF      = 7;
    localparam int          CTL_MK      = 6;
    localparam logic [7:0]  CTL_RST     = 8'h47;
    localparam logic [7:0]  CTL_WMASK   = 8'hC7;
    // status word flag positions
    localparam int          PSW_ID      = 5;
    localparam int          PSW_EP      = 6;
    localparam int          PSW_NP      = 7;
    localparam logic [31:0] PSW_RST     = 32'h0000_0020;
    // register indices (source controls at 0x00..0x36)
    localparam logic [7:0]  REG_CTL0    = 8'h00;
    localparam logic [7:0]  REG_PSW     = 8'h40;
    localparam logic [7:0]  REG_MS_PC   = 8'h41;
    localparam logic [7:0]  REG_MS_ST   = 8'h42;
    localparam logic [7:0]  REG_NS_PC   = 8'h43;
    localparam logic [7:0]  REG_NS_ST   = 8'h44;
    localparam logic [7:0]  REG_CAUSE   = 8'h45;
    localparam logic [7:0]  REG_IN_SERVICE_LEVEL_BITS    = 8'h46;
    // vectors: handler = base + step * source, cause code = handler
    localparam logic [31:0] VEC_BASE    = 32'h0000_0080;
    localparam int          VEC_SHIFT   = 4;
    localparam logic [31:0] NMI_VEC     = 32'h0000_0010;
    localparam logic [15:0] NMI_CODE    = 16'h0010;
endpackage : mic_pkg

/* File: rtl/mic_ctrl.sv */
/*
 * Maskable interrupt priority controller with processor-side entry and
 * return bookkeeping (saved PC/status, cause, status flags, in-service).
 * Assumes events, NMI, take and return strobes come from same-clock
 * logic, and the core samples pc_load_o/pc_value_o to redirect fetch.
 */
`timescale 1ns/100ps
module mic_ctrl (
    input  wire logic                        clock_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        ce_i,
    input  wire logic [mic_pkg::N_SRC-1:0]   irq_event_i,
    input  wire logic                        nmi_i,
    input  wire logic                        take_i,
    input  wire logic                        return_from_interrupt_i,
    input  wire logic [31:0]                 cpu_pc_i,
    input  wire logic [mic_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [31:0]                 wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [31:0]                 rdata_o,
    output logic                             irq_req_o,
    output logic                             pc_load_o,
    output logic      [31:0]                 pc_value_o,
    output logic      [31:0]                 psw_o
);
    logic [7:0]                ctl_ff [mic_pkg::N_SRC];
    logic [31:0]               psw_ff;
    logic [31:0]               ms_pc_ff;
    logic [31:0]               ms_st_ff;
    logic [31:0]               ns_pc_ff;
    logic [31:0]               ns_st_ff;
    logic [31:0]               cause_ff;
    logic [7:0]                in_service_level_bits_ff;
    logic                      win_vld_ff;
    logic [mic_pkg::IDX_W-1:0] win_idx_ff;
    logic [mic_pkg::LVL_W-1:0] win_lvl_ff;
    logic                      pc_load_ff;
    logic [31:0]               pc_value_ff;
    logic [31:0]               rdata_ff;
    logic                      nxt_vld;
    logic [mic_pkg::IDX_W-1:0] nxt_idx;
    logic [mic_pkg::LVL_W-1:0] nxt_lvl;
    logic [3:0]                cur_lvl;
    logic [7:0]                in_service_level_bits_low;
    logic                      nmi_take;
    logic                      mi_take;
    logic                      ret_ms;
    logic                      ret_ns;
    logic [31:0]               win_vec;
    logic [31:0]               nxt_rdata;

    // in-service level = lowest set bit; 8 means nothing in service
    always_comb begin
        cur_lvl  = 4'h8;
        in_service_level_bits_low = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (in_service_level_bits_ff[i]) begin
                cur_lvl  = 4'(i);
                in_service_level_bits_low = 8'(1 << i);
            end
        end
    end

    // combinational search, one winner each cycle
    always_comb begin
        nxt_vld = 1'b0;
        nxt_idx = 6'h00;
        nxt_lvl = 3'h7;
        for (int i = 0; i < mic_pkg::N_SRC; i++) begin
            // strict compare keeps lower index on tie
            if (ctl_ff[i][mic_pkg::CTL_IF] && !ctl_ff[i][mic_pkg::CTL_MK]
                && (!nxt_vld || ctl_ff[i][2:0] < nxt_lvl)) begin
                nxt_vld = 1'b1;
                nxt_idx = 6'(i);
                nxt_lvl = ctl_ff[i][2:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            win_vld_ff <= 1'b0;
            win_idx_ff <= 6'h00;
            win_lvl_ff <= 3'h7;
        end else if (ce_i) begin
            win_vld_ff <= nxt_vld;
            win_idx_ff <= nxt_idx;
            win_lvl_ff <= nxt_lvl;
        end
    end

    // disable or NMI service holds everything
    // only strictly higher level may nest
    // re-checks flag and mask: software may have changed them since
    assign irq_req_o = win_vld_ff && !psw_ff[mic_pkg::PSW_ID]
                       && !psw_ff[mic_pkg::PSW_NP]
                       && ctl_ff[win_idx_ff][mic_pkg::CTL_IF]
                       && !ctl_ff[win_idx_ff][mic_pkg::CTL_MK]
                       && ({1'b0, win_lvl_ff} < cur_lvl);

    // NMI refused while one is in service
    assign nmi_take = ce_i && nmi_i && !psw_ff[mic_pkg::PSW_NP];
    // NMI takes precedence over a simultaneous maskable entry
    assign mi_take  = ce_i && take_i && irq_req_o && !nmi_take;
    // return path chosen by pending and NMI flags
    assign ret_ms   = ce_i && return_from_interrupt_i && !nmi_take && !mi_take
                      && !psw_ff[mic_pkg::PSW_EP] && !psw_ff[mic_pkg::PSW_NP];
    assign ret_ns   = ce_i && return_from_interrupt_i && !nmi_take && !mi_take
                      && !psw_ff[mic_pkg::PSW_EP] && psw_ff[mic_pkg::PSW_NP];
    assign win_vec  = mic_pkg::VEC_BASE
                      + ({26'h0, win_idx_ff} << mic_pkg::VEC_SHIFT);

    // source control registers
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < mic_pkg::N_SRC; i++) begin
                ctl_ff[i] <= mic_pkg::CTL_RST;
            end
        end else if (ce_i) begin
            for (int i = 0; i < mic_pkg::N_SRC; i++) begin
                if (wr_i && addr_i == mic_pkg::REG_CTL0 + 8'(i)) begin
                    ctl_ff[i] <= wdata_i[7:0] & mic_pkg::CTL_WMASK;
                end
                if (mi_take && win_idx_ff == 6'(i)) begin
                    ctl_ff[i][mic_pkg::CTL_IF] <= 1'b0;
                end
                // event sets flag whatever the mask; wins clears
                if (irq_event_i[i]) begin
                    ctl_ff[i][mic_pkg::CTL_IF] <= 1'b1;
                end
            end
        end
    end

    // status word: entries beat return, return beats software load
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            psw_ff <= mic_pkg::PSW_RST;
        end else if (ce_i) begin
            if (nmi_take) begin
                psw_ff[mic_pkg::PSW_NP] <= 1'b1;
                psw_ff[mic_pkg::PSW_ID] <= 1'b1;
                psw_ff[mic_pkg::PSW_EP] <= 1'b0;
            end else if (mi_take) begin
                psw_ff[mic_pkg::PSW_ID] <= 1'b1;
                psw_ff[mic_pkg::PSW_EP] <= 1'b0;
            end else if (ret_ms) begin
                psw_ff <= ms_st_ff;
            end else if (ret_ns) begin
                psw_ff <= ns_st_ff;
            end else if (wr_i && addr_i == mic_pkg::REG_PSW) begin
                psw_ff <= wdata_i;
            end
        end
    end

    // saved context registers
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ms_pc_ff <= 32'h0000_0000;
            ms_st_ff <= 32'h0000_0000;
            ns_pc_ff <= 32'h0000_0000;
            ns_st_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            if (mi_take) begin
                // capture PC and status at entry
                ms_pc_ff <= cpu_pc_i;
                ms_st_ff <= psw_ff;
            end else begin
                if (wr_i && addr_i == mic_pkg::REG_MS_PC) ms_pc_ff <= wdata_i;
                if (wr_i && addr_i == mic_pkg::REG_MS_ST) ms_st_ff <= wdata_i;
            end
            if (nmi_take) begin
                ns_pc_ff <= cpu_pc_i;
                ns_st_ff <= psw_ff;
            end else begin
                if (wr_i && addr_i == mic_pkg::REG_NS_PC) ns_pc_ff <= wdata_i;
                if (wr_i && addr_i == mic_pkg::REG_NS_ST) ns_st_ff <= wdata_i;
            end
        end
    end

    // cause register: maskable low half, non-maskable high half
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cause_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            if (nmi_take) begin
                cause_ff[31:16] <= mic_pkg::NMI_CODE;
            end else if (mi_take) begin
                // low half only, high half kept
                cause_ff[15:0] <= win_vec[15:0];
            end else if (wr_i && addr_i == mic_pkg::REG_CAUSE) begin
                cause_ff <= wdata_i;
            end
        end
    end

    // in-service levels
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_service_level_bits_ff <= 8'h00;
        end else if (ce_i) begin
            if (mi_take) begin
                in_service_level_bits_ff <= in_service_level_bits_ff | 8'(1 << win_lvl_ff);
            end else if (ret_ms) begin
                // exited level is the highest one in service
                in_service_level_bits_ff <= in_service_level_bits_ff & ~in_service_level_bits_low;
            end
        end
    end

    // redirect to the core
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_load_ff  <= 1'b0;
            pc_value_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            pc_load_ff <= nmi_take || mi_take || ret_ms || ret_ns;
            if (nmi_take) begin
                pc_value_ff <= mic_pkg::NMI_VEC;
            end else if (mi_take) begin
                // handler address of the winning source
                pc_value_ff <= win_vec;
            end else if (ret_ms) begin
                pc_value_ff <= ms_pc_ff;
            end else if (ret_ns) begin
                pc_value_ff <= ns_pc_ff;
            end
        end
    end

    // register read, data in the following cycle; unmapped reads zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (addr_i < mic_pkg::REG_CTL0 + 8'(mic_pkg::N_SRC)) begin
            nxt_rdata = {24'h0, ctl_ff[6'(addr_i)]};
        end
        case (addr_i)
            mic_pkg::REG_PSW:   nxt_rdata = psw_ff;
            mic_pkg::REG_MS_PC: nxt_rdata = ms_pc_ff;
            mic_pkg::REG_MS_ST: nxt_rdata = ms_st_ff;
            mic_pkg::REG_NS_PC: nxt_rdata = ns_pc_ff;
            mic_pkg::REG_NS_ST: nxt_rdata = ns_st_ff;
            mic_pkg::REG_CAUSE: nxt_rdata = cause_ff;
            mic_pkg::REG_IN_SERVICE_LEVEL_BITS:  nxt_rdata = {24'h0, in_service_level_bits_ff};
            default:            nxt_rdata = nxt_rdata;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            rdata_ff <= rd_i ? nxt_rdata : 32'h0000_0000;
        end
    end

    assign rdata_o    = rdata_ff;
    assign pc_load_o  = pc_load_ff;
    assign pc_value_o = pc_value_ff;
    assign psw_o      = psw_ff;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_nmi_entry_np: assert property (
        nmi_take |=> psw_ff[mic_pkg::PSW_NP] && pc_load_ff
                     && pc_value_ff == mic_pkg::NMI_VEC)
        else $error("nmi entry did not set in-service flag");
    a_nmi_blocked: assert property (
        (ce_i && nmi_i && psw_ff[mic_pkg::PSW_NP]) |-> !nmi_take)
        else $error("nmi accepted while nmi in service");
    a_entry_disable: assert property (
        mi_take |=> psw_ff[mic_pkg::PSW_ID] && !psw_ff[mic_pkg::PSW_EP]
                    && pc_value_ff == $past(win_vec))
        else $error("maskable entry status or handler wrong");
    a_entry_save_pc: assert property (
        mi_take |=> ms_pc_ff == $past(cpu_pc_i) && ms_st_ff == $past(psw_ff))
        else $error("saved context not captured");
    a_cause_low_half: assert property (
        mi_take |=> cause_ff[15:0] == $past(win_vec[15:0])
                    && cause_ff[31:16] == $past(cause_ff[31:16]))
        else $error("cause register halves wrong");
    a_pend_disabled: assert property (
        irq_req_o |-> !psw_ff[mic_pkg::PSW_ID] && !psw_ff[mic_pkg::PSW_NP]
                      && !ctl_ff[win_idx_ff][mic_pkg::CTL_MK])
        else $error("request offered while disabled or masked");
    a_nest_strict: assert property (
        irq_req_o |-> {1'b0, win_lvl_ff} < cur_lvl)
        else $error("request not above in-service level");
    a_flag_cleared: assert property (
        (mi_take && !irq_event_i[win_idx_ff]) ##1 ce_i
        |-> !ctl_ff[$past(win_idx_ff)][mic_pkg::CTL_IF])
        else $error("request flag not cleared on acceptance");
    a_return_from_interrupt_restore: assert property (
        ret_ms |=> pc_load_ff && pc_value_ff == $past(ms_pc_ff)
                   && psw_ff == $past(ms_st_ff))
        else $error("return did not restore context");
    a_in_service_level_bits_clear: assert property (
        ret_ms |=> in_service_level_bits_ff == ($past(in_service_level_bits_ff) & ~$past(in_service_level_bits_low)))
        else $error("in-service bit not cleared on return");

    c_nested_entry: cover property (mi_take && in_service_level_bits_ff != 8'h00);
    c_nmi_entry: cover property (nmi_take);
    c_return_pair: cover property (mi_take ##[1:50] ret_ms);
endmodule : mic_ctrl

/* File: verif/mic_core_model.sv */
/*
 * Core stand-in: offers to take maskable entries, passes return
 * requests on, and follows every pc load from the controller.
 * Assumes the controller's clock and reset; the bench pulses ret_req_i.
 */
`timescale 1ns/100ps
module mic_core_model (
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic        slow_i,
    input  wire logic        ret_req_i,
    input  wire logic        pc_load_i,
    input  wire logic [31:0] pc_value_i,
    output logic             take_o,
    output logic             return_from_interrupt_o,
    output logic      [31:0] pc_o
);
    logic [1:0]  cnt_ff;
    logic [31:0] pc_ff;

    // follows a load in its own cycle: a take right after a return
    // must save the restored pc, not the old handler address
    assign pc_o = pc_load_i ? pc_value_i : pc_ff;

    // slow core is ready one cycle in four, so requests must wait
    assign take_o = !slow_i || cnt_ff == 2'h0;
    // bench clears pending bits before asking
    assign return_from_interrupt_o = ret_req_i;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= 2'h0;
            pc_ff  <= 32'h0000_1000;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
            if (pc_load_i) begin
                pc_ff <= pc_value_i;
            end
        end
    end
endmodule : mic_core_model

/* File: verif/mic_ctrl_bench.sv */
/*
 * Self-checking bench for mic_ctrl against a queue-based model.
 * Assumes mic_pkg and mic_core_model are compiled before this file.
 */
`timescale 1ns/100ps
module mic_ctrl_bench;
    logic                      clock_i, rst_b_i, ce_i, nmi_i, wr_i, rd_i;
    logic                      take_i, return_from_interrupt_i, irq_req_o, pc_load_o;
    logic                      slow, ret_req;
    logic [mic_pkg::N_SRC-1:0] irq_event_i;
    logic [7:0]                addr_i;
    logic [31:0]               wdata_i, rdata_o, pc_value_o, psw_o;
    logic [31:0]               cpu_pc_i, cur_pc;
    logic [31:0]               stk[$];
    logic [7:0]                isv;
    int                        n_mismatch, n_tests, seed;
    int                        lvl[55], msk[55], flg[55];

    mic_ctrl dut (.clock_i, .rst_b_i, .ce_i, .irq_event_i, .nmi_i,
        .take_i, .return_from_interrupt_i, .cpu_pc_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .irq_req_o, .pc_load_o, .pc_value_o, .psw_o);

    mic_core_model core (.clock_i, .rst_b_i, .slow_i (slow),
        .ret_req_i (ret_req), .pc_load_i (pc_load_o),
        .pc_value_i (pc_value_o), .take_o (take_i), .return_from_interrupt_o (return_from_interrupt_i),
        .pc_o (cpu_pc_i));

    always #50 clock_i = ~clock_i;

    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        @(negedge clock_i);
        v = rdata_o;
    endtask : rd_reg

    task automatic fire(input logic [54:0] m);
        @(posedge clock_i);
        irq_event_i <= m;
        @(posedge clock_i);
        irq_event_i <= '0;
        for (int n = 0; n < 55; n++) if (m[n]) flg[n] = 1;
    endtask : fire

    task automatic pulse_nmi();
        @(posedge clock_i);
        nmi_i <= 1'b1;
        @(posedge clock_i);
        nmi_i <= 1'b0;
    endtask : pulse_nmi

    task automatic pulse_ret();
        @(posedge clock_i);
        ret_req <= 1'b1;
        @(posedge clock_i);
        ret_req <= 1'b0;
    endtask : pulse_ret

    task automatic wait_load(input logic [31:0] exp);
        int i;
        i = 0;
        @(negedge clock_i);
        while (pc_load_o !== 1'b1 && i < 40) begin
            @(negedge clock_i);
            i++;
        end
        chk("pc_value", pc_value_o, exp);
    endtask : wait_load

    task automatic quiet();
        logic s;
        s = 1'b0;
        repeat (8) begin
            @(negedge clock_i);
            if (pc_load_o !== 1'b0 || irq_req_o !== 1'b0) s = 1'b1;
        end
        chk("quiet", {31'h0, s}, 32'h0);
    endtask : quiet

    // winner: lowest level first, then lowest index, below in-service
    function automatic int win();
        int b, lim;
        b = -1;
        lim = 8;
        for (int k = 7; k >= 0; k--) if (isv[k]) lim = k;
        for (int n = 0; n < 55; n++) begin
            if (flg[n] && !msk[n] && lvl[n] < lim &&
                (b < 0 || lvl[n] < lvl[b])) b = n;
        end
        return b;
    endfunction : win

    task automatic enter(input int n);
        logic [31:0] h, v;
        h = mic_pkg::VEC_BASE + (32'(n) << mic_pkg::VEC_SHIFT);
        wait_load(h);
        chk("psw_entry", psw_o & 32'hE0, 32'h20);
        rd_reg(mic_pkg::REG_MS_PC, v);
        chk("saved_pc", v, cur_pc);
        rd_reg(mic_pkg::REG_MS_ST, v);
        chk("saved_st", v, 32'h0);
        rd_reg(mic_pkg::REG_CAUSE, v);
        chk("cause", v, {mic_pkg::NMI_CODE, h[15:0]});
        stk.push_back(cur_pc);
        cur_pc = h;
        flg[n] = 0;
        isv[lvl[n]] = 1'b1;
        rd_reg(mic_pkg::REG_IN_SERVICE_LEVEL_BITS, v);
        chk("in_service", v, {24'h0, isv});
    endtask : enter

    task automatic leave();
        logic [31:0] v;
        int          k;
        pulse_ret();
        cur_pc = stk.pop_back();
        wait_load(cur_pc);
        chk("psw_ret", psw_o & 32'hE0, 32'h0);
        k = 0;
        while (k < 8 && !isv[k]) k++;
        if (k < 8) isv[k] = 1'b0;
        if (win() < 0) begin
            rd_reg(mic_pkg::REG_IN_SERVICE_LEVEL_BITS, v);
            chk("in_service", v, {24'h0, isv});
        end
    endtask : leave

    task automatic drain();
        while (win() >= 0) begin
            enter(win());
            leave();
        end
    endtask : drain

    task automatic cfg(input int n, input int l);
        wr_reg(8'(n), 32'(l));
        lvl[n] = l;
        msk[n] = 0;
    endtask : cfg

    initial begin
        logic [31:0] v;
        logic [63:0] r;
        {clock_i, rst_b_i, nmi_i, wr_i, rd_i, slow, ret_req} = 7'h0;
        ce_i = 1'b1;
        irq_event_i = '0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        {n_mismatch, n_tests, seed} = {32'd0, 32'd0, 32'd12};
        isv = 8'h00;
        cur_pc = 32'h0000_1000;
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1'b1;
        for (int n = 0; n < 55; n++) begin
            rd_reg(8'(n), v);
            chk("ctl_reset", v, 32'h47);
        end
        rd_reg(mic_pkg::REG_PSW, v);
        chk("psw_reset", v, 32'h20);
        rd_reg(8'h50, v);
        chk("unmapped", v, 32'h0);
        pulse_nmi();
        wait_load(mic_pkg::NMI_VEC);
        chk("psw_nmi", psw_o & 32'hE0, 32'hA0);
        pulse_nmi();
        quiet();
        pulse_ret();
        wait_load(cur_pc);
        chk("psw_nmi_ret", psw_o & 32'hE0, 32'h20);
        for (int k = 0; k < 5; k++) begin
            slow <= k[0];
            for (int n = 0; n < 55; n++) begin
                lvl[n] = $random(seed) & 7;
                msk[n] = ($random(seed) & 3) == 0;
                flg[n] = 0;
                wr_reg(8'(n), 32'(msk[n] * 64 + lvl[n]));
            end
            r = {$random(seed), $random(seed)};
            fire(r[54:0]);
            wr_reg(mic_pkg::REG_PSW, 32'h0);
            drain();
            quiet();
            for (int n = 0; n < 55; n++) begin
                rd_reg(8'(n), v);
                chk("ctl", v, 32'(flg[n]*128 + msk[n]*64 + lvl[n]));
            end
            wr_reg(mic_pkg::REG_PSW, 32'h20);
        end
        for (int n = 0; n < 55; n++) begin
            wr_reg(8'(n), 32'h47);
            {msk[n], lvl[n], flg[n]} = {32'd1, 32'd7, 32'd0};
        end
        cfg(5, 3);
        cfg(6, 3);
        cfg(7, 4);
        cfg(2, 2);
        wr_reg(mic_pkg::REG_PSW, 32'h0);
        fire(55'h20);
        enter(5);
        fire(55'hC0);
        rd_reg(mic_pkg::REG_MS_PC, v);
        wr_reg(mic_pkg::REG_PSW, 32'h0);
        quiet();
        fire(55'h4);
        enter(2);
        leave();
        quiet();
        wr_reg(mic_pkg::REG_PSW, 32'h20);
        wr_reg(mic_pkg::REG_MS_PC, v);
        wr_reg(mic_pkg::REG_MS_ST, 32'h0);
        leave();
        drain();
        // low clock enable must drop an event pulse
        wr_reg(mic_pkg::REG_PSW, 32'h20);
        @(posedge clock_i);
        ce_i        <= 1'b0;
        irq_event_i <= 55'h20;
        @(posedge clock_i);
        irq_event_i <= '0;
        ce_i        <= 1'b1;
        rd_reg(8'h05, v);
        chk("ce_frozen", v, 32'h03);
        print_verdict();
    end

    // about 40k cycles, several times the expected run length
    initial begin
        #4000000;
        n_mismatch++;
        print_verdict();
    end
endmodule : mic_ctrl_bench
